// >>> rcc_pkg.sv
// Shared constants of the radio core control and status register bank.
// Assumes a plain register port with byte addresses on 32-bit words.
package rcc_pkg;

    // =====================================================================
    // Register byte addresses.
    // =====================================================================
    localparam logic [31:0] ADDR_CORE_CONTROL_TWO     = 32'h4000_0200;
    localparam logic [31:0] ADDR_EXCHANGE_MEMORY_BASE = 32'h4000_0208;
    localparam logic [31:0] ADDR_DIAG_SELECT_UPPER    = 32'h4000_020c;
    localparam logic [31:0] ADDR_EVENT_STATUS         = 32'h4000_0280;
    localparam logic [31:0] ADDR_EVENT_MASK           = 32'h4000_0284;

    // =====================================================================
    // Field positions of core_control_two.
    // =====================================================================
    localparam int FREQ_MSB       = 14;
    localparam int FREQ_LSB       = 9;
    localparam int PWRDN_BIT      = 8;
    localparam int MON_BIT        = 7;
    localparam int CLK_STAT_BIT   = 6;
    localparam int DIAG_OVR_BIT   = 3;
    localparam int ERR_MASK_BIT   = 2;
    localparam int ERR_ACK_BIT    = 1;
    localparam int ERR_STAT_BIT   = 0;

    // =====================================================================
    // Field positions of exchange_memory_base and diagnostic_select_upper.
    // =====================================================================
    localparam int EM_BASE_MSB    = 16;
    localparam int EM_BASE_LSB    = 10;
    localparam int DIAG_CH7_ENABLE_BIT   = 31;
    localparam int DIAG_CH7_SELECT_SEL_MSB  = 29;
    localparam int DIAG_CH7_SELECT_SEL_LSB  = 24;

    // =====================================================================
    // Event status and mask layout.
    // =====================================================================
    localparam int EVT_ERR_BIT    = 0;
    localparam int EVT_SLEEP_BIT  = 1;
    localparam int EVT_PWRDN_BIT  = 2;
    localparam int EVT_WIDTH      = 3;

    // =====================================================================
    // Reset values.
    // =====================================================================
    localparam logic [5:0]  RST_FREQ      = 6'h00;
    localparam logic        RST_ERR_MASK  = 1'b1;
    localparam logic [6:0]  RST_EM_BASE   = 7'h00;
    localparam logic        RST_DIAG_CH7_ENABLE  = 1'b0;
    localparam logic [5:0]  RST_DIAG_CH7_SELECT_SEL = 6'h00;
    localparam logic [2:0]  RST_EVT_MASK  = 3'h0;

    // =====================================================================
    // Timing: slow clock edges from sleep request to power-down permission.
    // =====================================================================
    localparam logic [1:0]  PWRDN_LP_EDGES = 2'h2;

    // Sleep sequencer states.
    typedef enum logic [1:0] {
        RCC_AWAKE,
        RCC_COUNTING,
        RCC_ASLEEP
    } rcc_sleep_t;

endpackage

// >>> rcc_regs.sv
// Control and status register bank of the link-layer radio core.
// Assumes a single-cycle register port with no wait states, a slow clock
// arriving on a pin, and event pulses from core logic on i_ref_clk.
`timescale 1ns/1ps
module rcc_regs (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    // Register port.
    input  wire logic [31:0]  i_addr,
    input  wire logic [31:0]  i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic      [31:0]  o_rdata,
    // Core side.
    input  wire logic         i_slow_clk,
    input  wire logic         i_on_master_clock,
    input  wire logic         i_deep_sleep_request,
    input  wire logic         i_sleep_exit_irq,
    input  wire logic         i_mem_access_err_signal,
    input  wire logic [7:0]   i_core_diag_outputs,
    input  wire logic [511:0] i_diag_sources,
    output logic      [5:0]   o_master_freq_mhz,
    output logic      [6:0]   o_exchange_base_bits,
    output logic              o_powerdown_permitted,
    output logic              o_diag_override,
    output logic      [7:0]   o_diag_ch7_port,
    output logic      [7:0]   o_core_diag_outputs,
    output logic              o_core_error_irq,
    output logic              o_irq
);

    // =====================================================================
    // Declarations.
    // =====================================================================
    logic [5:0]             freq_r;
    logic                   pwrdn_r;
    logic                   mon_r;
    logic                   diag_ovr_r;
    logic                   err_mask_r;
    logic                   err_stat_r;
    logic [6:0]             em_base_r;
    logic                   diag_ch7_enable_r;
    logic [5:0]             diag_ch7_select_sel_r;
    logic [2:0]             evt_stat_r;
    logic [2:0]             evt_mask_r;
    logic [2:0]             evt_set;
    logic [1:0]             lp_cnt_r;
    logic                   slow_sync;
    logic                   slow_prev_r;
    logic                   slow_rise;
    logic                   clk_stat_sync;
    logic                   sleep_req_prev_r;
    logic                   sleep_req_rise;
    logic                   pwrdn_grant;
    logic                   wr_ctl;
    logic                   wr_base;
    logic                   wr_diag;
    logic                   wr_mask;
    logic                   rd_evt;
    logic [31:0]            rdata_nxt;
    logic [7:0]             diag_ch7_select_nxt;
    logic [7:0]             core_diag_nxt;
    rcc_pkg::rcc_sleep_t    sleep_r;

    // =====================================================================
    // Input synchronisers.
    // =====================================================================
    // The slow clock and the clock status come from other clock domains.
    rcc_sync #(
        .WIDTH (2)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_slow_clk, i_on_master_clock}),
        .o_sync    ({slow_sync, clk_stat_sync})
    );

    // Edge detection on the synchronised slow clock, never on the first stage.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slow_prev_r <= 1'b0;
        end else begin
            slow_prev_r <= slow_sync;
        end
    end

    assign slow_rise = slow_sync & ~slow_prev_r;

    // =====================================================================
    // Address decode.
    // =====================================================================
    // Writes to unmapped addresses are dropped without effect.
    assign wr_ctl  = i_wr && (i_addr == rcc_pkg::ADDR_CORE_CONTROL_TWO);
    assign wr_base = i_wr && (i_addr == rcc_pkg::ADDR_EXCHANGE_MEMORY_BASE);
    assign wr_diag = i_wr && (i_addr == rcc_pkg::ADDR_DIAG_SELECT_UPPER);
    assign wr_mask = i_wr && (i_addr == rcc_pkg::ADDR_EVENT_MASK);
    assign rd_evt  = i_rd && (i_addr == rcc_pkg::ADDR_EVENT_STATUS);

    // =====================================================================
    // Writable control fields of core_control_two.
    // =====================================================================
    // The frequency field is only a declaration; correct use depends on
    // software loading it before the core is enabled.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            freq_r     <= rcc_pkg::RST_FREQ;
            diag_ovr_r <= 1'b0;
            err_mask_r <= rcc_pkg::RST_ERR_MASK;
        end else if (wr_ctl) begin
            freq_r     <= i_wdata[rcc_pkg::FREQ_MSB:rcc_pkg::FREQ_LSB];
            diag_ovr_r <= i_wdata[rcc_pkg::DIAG_OVR_BIT];
            err_mask_r <= i_wdata[rcc_pkg::ERR_MASK_BIT];
        end
    end

    // =====================================================================
    // Slow clock edge monitor.
    // =====================================================================
    // A write of one is ignored; the hardware set wins over a clear in the
    // same cycle so no slow edge is ever lost.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mon_r <= 1'b0;
        end else if (slow_rise) begin
            mon_r <= 1'b1;
        end else if (wr_ctl && !i_wdata[rcc_pkg::MON_BIT]) begin
            mon_r <= 1'b0;
        end
    end

    // =====================================================================
    // Exchange memory access error status.
    // =====================================================================
    // An error arriving with the acknowledge keeps the status set.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            err_stat_r <= 1'b0;
        end else if (i_mem_access_err_signal) begin
            err_stat_r <= 1'b1;
        end else if (wr_ctl && i_wdata[rcc_pkg::ERR_ACK_BIT]) begin
            err_stat_r <= 1'b0;
        end
    end

    // Error interrupt level, held as long as status and mask are both one.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_error_irq <= 1'b0;
        end else begin
            o_core_error_irq <= err_stat_r & err_mask_r;
        end
    end

    // =====================================================================
    // Deep sleep sequencer.
    // =====================================================================
    // The grant is timed in slow clock edges, so it tracks the sleep timers
    // regardless of the master clock rate.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sleep_req_prev_r <= 1'b0;
        end else begin
            sleep_req_prev_r <= i_deep_sleep_request;
        end
    end

    assign sleep_req_rise = i_deep_sleep_request & ~sleep_req_prev_r;
    assign pwrdn_grant    = (sleep_r == rcc_pkg::RCC_COUNTING) && slow_rise
                            && (lp_cnt_r == rcc_pkg::PWRDN_LP_EDGES - 2'h1);

    // Sleep exit takes priority so a late request cannot grant power-down.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sleep_r  <= rcc_pkg::RCC_AWAKE;
            lp_cnt_r <= 2'h0;
        end else if (i_sleep_exit_irq) begin
            sleep_r  <= rcc_pkg::RCC_AWAKE;
            lp_cnt_r <= 2'h0;
        end else begin
            unique case (sleep_r)
                rcc_pkg::RCC_AWAKE: begin
                    lp_cnt_r <= 2'h0;
                    if (sleep_req_rise) begin
                        sleep_r <= rcc_pkg::RCC_COUNTING;
                    end
                end
                rcc_pkg::RCC_COUNTING: begin
                    if (pwrdn_grant) begin
                        sleep_r <= rcc_pkg::RCC_ASLEEP;
                    end else if (slow_rise) begin
                        lp_cnt_r <= lp_cnt_r + 2'h1;
                    end
                end
                rcc_pkg::RCC_ASLEEP: begin
                    lp_cnt_r <= 2'h0;
                end
                default: begin
                    sleep_r <= rcc_pkg::RCC_AWAKE;
                end
            endcase
        end
    end

    // Power-down permission flag, cleared together with the sleep exit event.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwrdn_r <= 1'b0;
        end else if (i_sleep_exit_irq) begin
            pwrdn_r <= 1'b0;
        end else if (pwrdn_grant) begin
            pwrdn_r <= 1'b1;
        end
    end

    // =====================================================================
    // Exchange memory base and diagnostic channel seven selection.
    // =====================================================================
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            em_base_r <= rcc_pkg::RST_EM_BASE;
        end else if (wr_base) begin
            em_base_r <= i_wdata[rcc_pkg::EM_BASE_MSB:rcc_pkg::EM_BASE_LSB];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            diag_ch7_enable_r  <= rcc_pkg::RST_DIAG_CH7_ENABLE;
            diag_ch7_select_sel_r <= rcc_pkg::RST_DIAG_CH7_SELECT_SEL;
        end else if (wr_diag) begin
            diag_ch7_enable_r  <= i_wdata[rcc_pkg::DIAG_CH7_ENABLE_BIT];
            diag_ch7_select_sel_r <= i_wdata[rcc_pkg::DIAG_CH7_SELECT_SEL_MSB:rcc_pkg::DIAG_CH7_SELECT_SEL_LSB];
        end
    end

    // =====================================================================
    // Diagnostic outputs.
    // =====================================================================
    // Channel seven picks one of 64 byte groups; disabled it drives zeros.
    // When overridden, the core diagnostic byte shows channel seven instead.
    always_comb begin
        diag_ch7_select_nxt = 8'h00;
        if (diag_ch7_enable_r) begin
            diag_ch7_select_nxt = i_diag_sources[{diag_ch7_select_sel_r, 3'h0} +: 8];
        end
        core_diag_nxt = diag_ovr_r ? diag_ch7_select_nxt : i_core_diag_outputs;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_diag_ch7_port     <= 8'h00;
            o_core_diag_outputs <= 8'h00;
        end else begin
            o_diag_ch7_port     <= diag_ch7_select_nxt;
            o_core_diag_outputs <= core_diag_nxt;
        end
    end

    // =====================================================================
    // Event status, mask and summary interrupt.
    // =====================================================================
    assign evt_set[rcc_pkg::EVT_ERR_BIT]   = i_mem_access_err_signal;
    assign evt_set[rcc_pkg::EVT_SLEEP_BIT] = i_sleep_exit_irq;
    assign evt_set[rcc_pkg::EVT_PWRDN_BIT] = pwrdn_grant;

    // A read clears the sticky bits, but an event in that cycle stays set.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            evt_stat_r <= 3'h0;
        end else if (rd_evt) begin
            evt_stat_r <= evt_set;
        end else begin
            evt_stat_r <= evt_stat_r | evt_set;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            evt_mask_r <= rcc_pkg::RST_EVT_MASK;
        end else if (wr_mask) begin
            evt_mask_r <= i_wdata[rcc_pkg::EVT_WIDTH-1:0];
        end
    end

    // The interrupt follows status one cycle later to come from a flop.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(evt_stat_r & evt_mask_r);
        end
    end

    // =====================================================================
    // Read path.
    // =====================================================================
    // Reserved, write-only and unmapped bits all read as zero.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (i_rd) begin
            unique case (i_addr)
                rcc_pkg::ADDR_CORE_CONTROL_TWO: begin
                    rdata_nxt[rcc_pkg::FREQ_MSB:rcc_pkg::FREQ_LSB] = freq_r;
                    rdata_nxt[rcc_pkg::PWRDN_BIT]    = pwrdn_r;
                    rdata_nxt[rcc_pkg::MON_BIT]      = mon_r;
                    rdata_nxt[rcc_pkg::CLK_STAT_BIT] = clk_stat_sync;
                    rdata_nxt[rcc_pkg::DIAG_OVR_BIT] = diag_ovr_r;
                    rdata_nxt[rcc_pkg::ERR_MASK_BIT] = err_mask_r;
                    rdata_nxt[rcc_pkg::ERR_ACK_BIT]  = 1'b0;
                    rdata_nxt[rcc_pkg::ERR_STAT_BIT] = err_stat_r;
                end
                rcc_pkg::ADDR_EXCHANGE_MEMORY_BASE: begin
                    rdata_nxt[rcc_pkg::EM_BASE_MSB:rcc_pkg::EM_BASE_LSB] = em_base_r;
                end
                rcc_pkg::ADDR_DIAG_SELECT_UPPER: begin
                    rdata_nxt[rcc_pkg::DIAG_CH7_ENABLE_BIT] = diag_ch7_enable_r;
                    rdata_nxt[rcc_pkg::DIAG_CH7_SELECT_SEL_MSB:rcc_pkg::DIAG_CH7_SELECT_SEL_LSB] = diag_ch7_select_sel_r;
                end
                rcc_pkg::ADDR_EVENT_STATUS: begin
                    rdata_nxt[rcc_pkg::EVT_WIDTH-1:0] = evt_stat_r;
                end
                rcc_pkg::ADDR_EVENT_MASK: begin
                    rdata_nxt[rcc_pkg::EVT_WIDTH-1:0] = evt_mask_r;
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= rdata_nxt;
        end
    end

    // =====================================================================
    // Plain field outputs.
    // =====================================================================
    assign o_master_freq_mhz     = freq_r;
    assign o_exchange_base_bits  = em_base_r;
    assign o_powerdown_permitted = pwrdn_r;
    assign o_diag_override       = diag_ovr_r;

endmodule

// >>> rcc_regs_sva.sv
// Port-level checker for the radio core control and status register bank.
// Assumes it is bound to rcc_regs and sees only that module's ports.
`timescale 1ns/1ps
module rcc_regs_sva (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        i_deep_sleep_request,
    input wire logic        i_sleep_exit_irq,
    input wire logic        i_mem_access_err_signal,
    input wire logic [7:0]  i_core_diag_outputs,
    input wire logic [5:0]  o_master_freq_mhz,
    input wire logic [6:0]  o_exchange_base_bits,
    input wire logic        o_powerdown_permitted,
    input wire logic        o_diag_override,
    input wire logic [7:0]  o_core_diag_outputs,
    input wire logic        o_core_error_irq
);
    // ==================================================================
    // Decoded writes, kept as plain nets so the properties stay short.
    // ==================================================================
    wire ctl_wr  = i_wr && (i_addr == rcc_pkg::ADDR_CORE_CONTROL_TWO);
    wire base_wr = i_wr && (i_addr == rcc_pkg::ADDR_EXCHANGE_MEMORY_BASE);

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // ==================================================================
    // Properties.
    // ==================================================================
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    chk_freq_write: assert property (ctl_wr |=> o_master_freq_mhz == $past(i_wdata[14:9]))
        else $error("frequency field not written");
    chk_base_write: assert property (
        base_wr |=> o_exchange_base_bits == $past(i_wdata[16:10]))
        else $error("base field not written");
    chk_ovr_write: assert property (ctl_wr |=> o_diag_override == $past(i_wdata[3]))
        else $error("override bit not written");
    chk_diag_pass: assert property (
        !o_diag_override |=> o_core_diag_outputs == $past(i_core_diag_outputs))
        else $error("diagnostic byte altered without override");
    chk_pwrdn_clear: assert property (i_sleep_exit_irq |=> !o_powerdown_permitted)
        else $error("power-down permission kept after sleep exit");
    chk_pwrdn_cause: assert property (
        $rose(o_powerdown_permitted) |-> $past(i_deep_sleep_request, 3))
        else $error("power-down granted without sleep request");
    chk_err_fall: assert property ($fell(o_core_error_irq) |-> $past(ctl_wr, 2))
        else $error("error interrupt dropped without control write");
    chk_err_rise: assert property (
        $rose(o_core_error_irq) |-> $past(i_mem_access_err_signal, 2) || $past(ctl_wr, 2))
        else $error("error interrupt raised without cause");
endmodule

bind rcc_regs rcc_regs_sva u_sva (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_deep_sleep_request, .i_sleep_exit_irq, .i_mem_access_err_signal,
    .i_core_diag_outputs, .o_master_freq_mhz, .o_exchange_base_bits, .o_powerdown_permitted,
    .o_diag_override, .o_core_diag_outputs, .o_core_error_irq);

// >>> rcc_regs_test.sv
// Self-checking testbench of the radio core control and status registers.
// Assumes rcc_regs with a one-cycle register port and a slow clock pin.
`timescale 1ns/1ps
module rcc_regs_test;
    localparam logic [31:0] CTL = rcc_pkg::ADDR_CORE_CONTROL_TWO;
    localparam logic [31:0] EVT = rcc_pkg::ADDR_EVENT_STATUS;
    logic         i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic         i_slow_clk = 1'b0, i_on_master_clock = 1'b0, i_deep_sleep_request = 1'b0;
    logic         i_sleep_exit_irq = 1'b0, i_mem_access_err_signal = 1'b0;
    logic [31:0]  i_addr = 32'h0, i_wdata = 32'h0, o_rdata;
    logic [7:0]   i_core_diag_outputs = 8'ha5, o_diag_ch7_port, o_core_diag_outputs;
    logic [511:0] i_diag_sources;
    logic [5:0]   o_master_freq_mhz;
    logic [6:0]   o_exchange_base_bits;
    logic         o_powerdown_permitted, o_diag_override, o_core_error_irq, o_irq;
    int           fail_count = 0, tests_run = 0;

    rcc_regs u_dut (.i_ref_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_slow_clk, .i_on_master_clock, .i_deep_sleep_request, .i_sleep_exit_irq,
        .i_mem_access_err_signal, .i_core_diag_outputs, .i_diag_sources, .o_master_freq_mhz,
        .o_exchange_base_bits, .o_powerdown_permitted, .o_diag_override, .o_diag_ch7_port,
        .o_core_diag_outputs, .o_core_error_irq, .o_irq);

    // ==================================================================
    // Clock and helpers.
    // ==================================================================
    always #2.5 i_ref_clk = ~i_ref_clk;

    task automatic tally_and_finish();
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Writes hold the strobe for exactly one edge; address and data stay until the next access.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    // Read data are only valid in the cycle after the strobe, so sample there.
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(n, e, o_rdata);
    endtask
    // Slow edges last many fast cycles so the synchroniser sees each one.
    task automatic slow(input int n);
        repeat (n) begin
            @(posedge i_ref_clk) i_slow_clk <= 1'b1;
            repeat (4) @(posedge i_ref_clk);
            i_slow_clk <= 1'b0;
            cyc(4);
        end
    endtask

    // ==================================================================
    // Scenarios.
    // ==================================================================
    task automatic t_fields();
        rd(CTL, 32'h4, "ctl reset");
        rd(32'h4000_0204, 32'h0, "unmapped");
        rd(32'h4000_0284, 32'h0, "mask reset");
        wr(CTL, 32'hffff_ffff);
        rd(CTL, 32'h7e0c, "ctl all ones");
        wr(CTL, 32'h2004);
        wr(32'h4000_0208, 32'hffff_ffff);
        rd(32'h4000_0208, 32'h1fc00, "base");
        chk("base out", 32'h7f, {25'h0, o_exchange_base_bits});
        chk("freq", 32'h10, {26'h0, o_master_freq_mhz});
        wr(32'h4000_020c, 32'hffff_ffff);
        rd(32'h4000_020c, 32'hbf00_0000, "diag sel");
    endtask
    task automatic t_diag();
        wr(32'h4000_020c, 32'h8500_0000);
        cyc(3);
        chk("ch7 on", 32'h45, {24'h0, o_diag_ch7_port});
        chk("diag pass", 32'ha5, {24'h0, o_core_diag_outputs});
        wr(CTL, 32'h200c);
        cyc(3);
        chk("diag ovr", 32'h45, {24'h0, o_core_diag_outputs});
        chk("ovr out", 32'h1, {31'h0, o_diag_override});
        wr(32'h4000_020c, 32'h0500_0000);
        cyc(3);
        chk("ch7 off", 32'h0, {24'h0, o_diag_ch7_port});
        wr(CTL, 32'h2004);
    endtask
    task automatic t_mon();
        slow(1);
        rd(CTL, 32'h2084, "mon set");
        wr(CTL, 32'h2084);
        rd(CTL, 32'h2084, "mon keep");
        wr(CTL, 32'h2004);
        rd(CTL, 32'h2004, "mon clear");
        @(posedge i_ref_clk) i_on_master_clock <= 1'b1;
        cyc(4);
        rd(CTL, 32'h2044, "clk stat");
        @(posedge i_ref_clk) i_on_master_clock <= 1'b0;
        cyc(4);
    endtask
    task automatic t_err();
        wr(32'h4000_0284, 32'h7);
        @(posedge i_ref_clk) i_mem_access_err_signal <= 1'b1;
        @(posedge i_ref_clk) i_mem_access_err_signal <= 1'b0;
        cyc(2);
        chk("err irq", 32'h1, {31'h0, o_core_error_irq});
        rd(CTL, 32'h2005, "err stat");
        wr(CTL, 32'h2000);
        cyc(2);
        chk("err masked", 32'h0, {31'h0, o_core_error_irq});
        wr(CTL, 32'h2004);
        cyc(2);
        chk("err unmasked", 32'h1, {31'h0, o_core_error_irq});
        wr(CTL, 32'h2006);
        rd(CTL, 32'h2004, "err ack");
        chk("irq evt", 32'h1, {31'h0, o_irq});
        rd(EVT, 32'h1, "evt err");
        cyc(2);
        chk("irq clr", 32'h0, {31'h0, o_irq});
    endtask
    task automatic t_sleep();
        @(posedge i_ref_clk) i_deep_sleep_request <= 1'b1;
        slow(1);
        chk("pwrdn early", 32'h0, {31'h0, o_powerdown_permitted});
        slow(1);
        chk("pwrdn grant", 32'h1, {31'h0, o_powerdown_permitted});
        rd(CTL, 32'h2184, "pwrdn bit");
        @(posedge i_ref_clk) i_sleep_exit_irq <= 1'b1;
        @(posedge i_ref_clk) i_sleep_exit_irq <= 1'b0;
        i_deep_sleep_request <= 1'b0;
        cyc(1);
        chk("pwrdn exit", 32'h0, {31'h0, o_powerdown_permitted});
        rd(EVT, 32'h6, "evt sleep");
    endtask

    // ==================================================================
    // Main sequence and watchdog.
    // ==================================================================
    initial begin
        for (int k = 0; k < 64; k++) i_diag_sources[k*8 +: 8] = 8'(8'h40 + k);
        repeat (5) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_fields();
        t_diag();
        t_mon();
        t_err();
        t_sleep();
        tally_and_finish();
    end
    // The scenarios need well under a thousand cycles; this cuts a hang.
    initial begin
        #20000;
        fail_count++;
        tally_and_finish();
    end
endmodule

// >>> rcc_sync.sv
// Two-flop synchroniser for a level coming from outside the clock domain.
// Assumes the input is a level that stays stable for several clock cycles.
`timescale 1ns/1ps
module rcc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;

    // =====================================================================
    // Synchroniser chain.
    // =====================================================================
    // Only the second stage is visible, so metastability stays contained.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule
